// ===== breaker_model.sv
// behavioural circuit breaker with its closed feedback contact
`timescale 1ns/10ps
`default_nettype none
module breaker_model (
   input wire logic clk_in, // clock
   input wire logic rst_n_in, // reset
   input wire logic open_in, // opening operation
   input wire logic close_in, // closure command
   input wire logic stuck_in, // mechanism jammed closed
   input wire logic force_in, // closed by someone else
   output logic closed_out // feedback closed
);
   // opening wins over a held closure so a healthy breaker always opens
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         closed_out <= 1'b0;
      end else if (open_in && !stuck_in) begin
         closed_out <= 1'b0;
      end else if (close_in || force_in) begin
         closed_out <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ===== genset_protection_monitor.sv
// generator-set protection monitor with apb register access
// Functional notes
// R1: contact overspeed alarm after input active for its delay; zero delay disables.
// R2: both overspeed alarms suppressed while stopped, starting or filter regenerating.
// R3: measured overspeed alarm when speed stays above threshold for delay; zero disables.
// R4: measured overspeed inactive when no speed source is configured.
// R5: aux battery high warning when voltage above percent threshold for delay.
// R6: aux battery warning inactive when nothing is connected to its terminal.
// R7: engine-not-stopped alarm when still running stop-cycle seconds after stop.
// R8: engine-not-stopped alarm also when engine runs without a start command.
// R9: engine-not-started after crank attempts; warning in manual, alarm in auto.
// R10: breaker opening attempt fails when feedback not open within delay.
// R11: zero feedback delay disables, but parallel use substitutes two seconds.
// R12: manual mode raises breaker-not-opened after one failed attempt.
// R13: auto mode needs three failures, one when stable closure command used.
// R14: breaker-not-opened also raised on closure the device did not command.
// R15: graded warning; deactivation on unsolicited closure or no-parallel systems.
// R16: breaker protection inactive if breaker unmanaged or feedback not acquired.
// R17: keep-running option keeps engine running on generator breaker warning.
// R18: open-mains option opens mains breaker when generator breaker stuck and stopping.
// R19: battery and not-stopped evaluated always; others only outside off mode.
// R20: every delay timer restarts when its condition clears early.
`timescale 1ns/10ps
`default_nettype none
module genset_protection_monitor #(
   parameter int TICK_DIV = protmon_pkg::TICK_CYCLES
) (
   input wire logic CLOCK_IN, // 100 MHz system clock
   input wire logic RST_N_IN, // async active-low reset
   input wire logic PSEL_IN, // apb select
   input wire logic PENABLE_IN, // apb enable
   input wire logic PWRITE_IN, // apb direction
   input wire logic [7:0] PADDR_IN, // apb byte address
   input wire logic [31:0] PWDATA_IN, // apb write data
   output logic [31:0] PRDATA_OUT, // apb read data
   output logic PREADY_OUT, // apb ready
   output logic PSLVERR_OUT, // apb error on unmapped address
   input wire logic OVERSPEED_CONTACT_IN, // overspeed input function contact
   input wire logic ENGINE_RUNNING_IN, // engine running indication
   input wire logic ENGINE_STARTING_IN, // engine in start phase
   input wire logic DPF_REGEN_IN, // particulate filter regeneration running
   input wire logic START_CMD_IN, // device start command active
   input wire logic STOP_CMD_IN, // device stop command active
   input wire logic CRANK_FAIL_IN, // pulse: last crank attempt failed to start
   input wire logic MCB_OPEN_CMD_IN, // mains breaker opening operation
   input wire logic MCB_CLOSE_CMD_IN, // mains breaker closure commanded
   input wire logic MCB_CLOSED_FB_IN, // mains breaker feedback closed
   input wire logic GCB_OPEN_CMD_IN, // generator breaker opening operation
   input wire logic GCB_CLOSE_CMD_IN, // generator breaker closure commanded
   input wire logic GCB_CLOSED_FB_IN, // generator breaker feedback closed
   input wire logic [15:0] SPEED_RPM_IN, // measured engine speed
   input wire logic [15:0] AUX_BAT_PCT_IN, // aux battery, percent of rated
   output logic [11:0] PROT_OUT, // protection flags, status bit layout
   output logic KEEP_RUNNING_OUT, // keep engine running with gen breaker closed
   output logic MCB_OPEN_REQ_OUT // request to open the mains breaker
);
   localparam int TW = $clog2(TICK_DIV + 1);

   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] ovs_cfg; // [15:0] contact delay ms, [31:16] measured delay ms
      logic [31:0] bat_cfg; // [15:0] threshold percent, [31:16] delay ms
      logic [31:0] stop_cfg; // [15:0] stop cycle s, [31:16] speed threshold
      logic [31:0] cb_cfg; // [15:0] mcb fb delay ms, [31:16] gcb fb delay ms
      logic [TW-1:0] tick_cnt;
      logic tick;
      logic [15:0] t_cov, t_mov, t_bat, t_stop, t_mcb, t_gcb;
      logic [9:0] t_ms;
      logic [7:0] cranks;
      logic crank_d; // last synchronised crank level, for edge detection
      logic [1:0] mcb_fails, gcb_fails;
      logic [11:0] prot;
      logic [31:0] prdata;
      logic pready, pslverr;
      logic [11:0] sync1, sync2;
   } state_s;

   state_s cur_ff, nxt_ff;
   logic [1:0] rst_sync_ff;
   wire logic rst_n = rst_sync_ff[1];

   // delay step: count ticks while condition stays, restart from zero when it clears
   function automatic logic [15:0] step(input logic cond, input logic tick,
                                        input logic [15:0] t);
      if (!cond)
         step = 16'h0000; // [R20]
      else if (tick && t != 16'hFFFF)
         step = t + 16'h0001;
      else
         step = t;
   endfunction

   // failed-attempt limit per mode
   function automatic logic [1:0] limit(input logic [1:0] mode, input logic stable);
      if (mode == protmon_pkg::MODE_AUTO && !stable)
         limit = protmon_pkg::AUTO_ATTEMPTS; // [R13]
      else
         limit = protmon_pkg::ONE_ATTEMPT; // [R12]
   endfunction

   // reset release through two flops
   always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN)
         rst_sync_ff <= 2'h0;
      else
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
   end

   // all state except the reset synchroniser in one struct
   always_ff @(posedge CLOCK_IN or negedge rst_n) begin
      if (!rst_n)
         cur_ff <= '0;
      else
         cur_ff <= nxt_ff;
   end

   // next-state logic
   always_comb begin
      logic [11:0] pin;
      logic ov, start_ph, stopped, on, en_ovs, auto_m, man_m, wr, rd;
      logic [15:0] mdly, gdly, stop_ms;
      logic mcb_en, gcb_en, mcb_uns, gcb_uns, mcb_t, gcb_t, mcb_hit, gcb_hit;
      logic [1:0] mode;
      // every local gets a value first so no path can leave one stale
      pin = 12'h000;
      ov = 1'b0;
      start_ph = 1'b0;
      stopped = 1'b0;
      on = 1'b0;
      en_ovs = 1'b0;
      auto_m = 1'b0;
      man_m = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      mdly = 16'h0000;
      gdly = 16'h0000;
      stop_ms = 16'h0000;
      mcb_en = 1'b0;
      gcb_en = 1'b0;
      mcb_uns = 1'b0;
      gcb_uns = 1'b0;
      mcb_t = 1'b0;
      gcb_t = 1'b0;
      mcb_hit = 1'b0;
      gcb_hit = 1'b0;
      mode = 2'h0;
      nxt_ff = cur_ff;
      // single-bit engine and breaker pins except GCB_CLOSE_CMD_IN pass two flops; MCB_CLOSE_CMD_IN is also used raw
      nxt_ff.sync1 = {OVERSPEED_CONTACT_IN, ENGINE_RUNNING_IN, ENGINE_STARTING_IN,
                      DPF_REGEN_IN, START_CMD_IN, STOP_CMD_IN, CRANK_FAIL_IN,
                      MCB_OPEN_CMD_IN, MCB_CLOSE_CMD_IN, MCB_CLOSED_FB_IN,
                      GCB_OPEN_CMD_IN, GCB_CLOSED_FB_IN};
      nxt_ff.sync2 = cur_ff.sync1;
      pin = cur_ff.sync2;
      mode = cur_ff.ctrl[protmon_pkg::CTRL_MODE_LSB +: 2];
      on = (mode != protmon_pkg::MODE_OFF); // [R19]
      man_m = (mode == protmon_pkg::MODE_MAN);
      auto_m = (mode == protmon_pkg::MODE_AUTO);
      stopped = !pin[10];
      start_ph = pin[9];
      en_ovs = on && !stopped && !start_ph && !pin[8]; // [R2]

      // millisecond tick from the system clock
      nxt_ff.tick = 1'b0;
      if (cur_ff.tick_cnt == TW'(TICK_DIV - 1)) begin
         nxt_ff.tick_cnt = '0;
         nxt_ff.tick = 1'b1;
      end else begin
         nxt_ff.tick_cnt = cur_ff.tick_cnt + TW'(1);
      end
      // the second count starts at the stop command, so a partial first
      // second cannot shorten the stopping cycle
      if (!pin[6] || (cur_ff.tick && cur_ff.t_ms == 10'(protmon_pkg::MS_PER_S - 1)))
         nxt_ff.t_ms = 10'h000;
      else if (cur_ff.tick)
         nxt_ff.t_ms = cur_ff.t_ms + 10'h001;

      // contact overspeed
      nxt_ff.t_cov = step(en_ovs && pin[11], cur_ff.tick, cur_ff.t_cov);
      nxt_ff.prot[protmon_pkg::ST_CONTACT_OVS] = en_ovs && pin[11]
         && cur_ff.ovs_cfg[15:0] != 16'h0000
         && cur_ff.t_cov >= cur_ff.ovs_cfg[15:0]; // [R1]
      // measured overspeed; needs a configured speed source
      ov = en_ovs && cur_ff.ctrl[protmon_pkg::CTRL_SPEED_SRC] // [R4]
           && SPEED_RPM_IN > cur_ff.stop_cfg[31:16];
      nxt_ff.t_mov = step(ov, cur_ff.tick, cur_ff.t_mov);
      nxt_ff.prot[protmon_pkg::ST_MEAS_OVS] = ov && cur_ff.ovs_cfg[31:16] != 16'h0000
         && cur_ff.t_mov >= cur_ff.ovs_cfg[31:16]; // [R3]
      // aux battery high, any mode
      ov = cur_ff.ctrl[protmon_pkg::CTRL_AUX_BAT_CONN] // [R6]
           && AUX_BAT_PCT_IN > cur_ff.bat_cfg[15:0];
      nxt_ff.t_bat = step(ov, cur_ff.tick, cur_ff.t_bat);
      nxt_ff.prot[protmon_pkg::ST_AUX_BAT] = ov && cur_ff.bat_cfg[31:16] != 16'h0000
         && cur_ff.t_bat >= cur_ff.bat_cfg[31:16]; // [R5]

      // engine not stopped: seconds counted from stop command, any mode
      ov = pin[6] && pin[10];
      nxt_ff.t_stop = step(pin[6], cur_ff.tick
         && cur_ff.t_ms == 10'(protmon_pkg::MS_PER_S - 1), cur_ff.t_stop); // [R7]
      stop_ms = cur_ff.stop_cfg[15:0];
      nxt_ff.prot[protmon_pkg::ST_NOT_STOP] =
         (ov && stop_ms != 16'h0000 && cur_ff.t_stop >= stop_ms) // [R7]
         || (pin[10] && !pin[7] && !pin[6] && !start_ph); // [R8]

      // engine not started: count failed cranks against limit
      // a third stage holds the old level so the synchroniser stays untouched
      nxt_ff.crank_d = pin[5];
      if (!on || pin[10])
         nxt_ff.cranks = 8'h00;
      else if (pin[5] && !cur_ff.crank_d && cur_ff.cranks != 8'hFF)
         nxt_ff.cranks = cur_ff.cranks + 8'h01;
      ov = on && cur_ff.cranks != 8'h00
           && cur_ff.cranks >= cur_ff.ctrl[23:16]; // [R9]
      nxt_ff.prot[protmon_pkg::ST_NOT_START_WARN] = ov && man_m;
      nxt_ff.prot[protmon_pkg::ST_NOT_START_ALARM] = ov && auto_m;

      // breaker feedback delays; parallel use forces two seconds on zero
      mdly = cur_ff.cb_cfg[15:0];
      gdly = cur_ff.cb_cfg[31:16];
      if (cur_ff.ctrl[protmon_pkg::CTRL_PARALLEL] && mdly == 16'h0000)
         mdly = protmon_pkg::PAR_FB_DELAY_MS; // [R11]
      if (cur_ff.ctrl[protmon_pkg::CTRL_PARALLEL] && gdly == 16'h0000)
         gdly = protmon_pkg::PAR_FB_DELAY_MS; // [R11]
      mcb_en = on && cur_ff.ctrl[protmon_pkg::CTRL_MCB_MANAGED]
               && cur_ff.ctrl[protmon_pkg::CTRL_MCB_FB_USED] && mdly != 16'h0000; // [R16]
      gcb_en = on && cur_ff.ctrl[protmon_pkg::CTRL_GCB_MANAGED]
               && cur_ff.ctrl[protmon_pkg::CTRL_GCB_FB_USED] && gdly != 16'h0000; // [R16]
      mcb_t = mcb_en && pin[4] && pin[2];
      gcb_t = gcb_en && pin[1] && pin[0];
      nxt_ff.t_mcb = step(mcb_t, cur_ff.tick, cur_ff.t_mcb);
      nxt_ff.t_gcb = step(gcb_t, cur_ff.tick, cur_ff.t_gcb);
      // count on the tick that brings the timer to the delay, like the other timers
      mcb_hit = mcb_t && cur_ff.t_mcb == mdly - 16'h0001 && cur_ff.tick; // [R10]
      gcb_hit = gcb_t && cur_ff.t_gcb == gdly - 16'h0001 && cur_ff.tick; // [R10]
      // an attempt that ended in open clears the count
      if (!mcb_en || (pin[4] && !pin[2]))
         nxt_ff.mcb_fails = 2'h0;
      else if (mcb_hit && cur_ff.mcb_fails != 2'h3)
         nxt_ff.mcb_fails = cur_ff.mcb_fails + 2'h1;
      if (!gcb_en || (pin[1] && !pin[0]))
         nxt_ff.gcb_fails = 2'h0;
      else if (gcb_hit && cur_ff.gcb_fails != 2'h3)
         nxt_ff.gcb_fails = cur_ff.gcb_fails + 2'h1;
      mcb_uns = mcb_en && pin[2] && !MCB_CLOSE_CMD_IN && !pin[4] && !pin[3]; // [R14]
      gcb_uns = gcb_en && pin[0] && !GCB_CLOSE_CMD_IN && !pin[1]; // [R14]
      ov = mcb_en && cur_ff.mcb_fails >= limit(mode, cur_ff.ctrl[protmon_pkg::CTRL_STABLE_CLOSE]);
      nxt_ff.prot[protmon_pkg::ST_MCB_FAIL] = ov || mcb_uns;
      nxt_ff.prot[protmon_pkg::ST_MCB_DEACT] = mcb_uns
         || (ov && cur_ff.ctrl[protmon_pkg::CTRL_NO_PARALLEL]); // [R15]
      ov = gcb_en && cur_ff.gcb_fails >= limit(mode, cur_ff.ctrl[protmon_pkg::CTRL_STABLE_CLOSE]);
      nxt_ff.prot[protmon_pkg::ST_GCB_FAIL] = ov || gcb_uns;
      nxt_ff.prot[protmon_pkg::ST_GCB_DEACT] = gcb_uns
         || (ov && cur_ff.ctrl[protmon_pkg::CTRL_NO_PARALLEL]); // [R15]
      // keep running only when the generator breaker fault is a plain warning
      nxt_ff.prot[protmon_pkg::ST_KEEP_RUN] = cur_ff.ctrl[protmon_pkg::CTRL_KEEP_RUN]
         && cur_ff.prot[protmon_pkg::ST_GCB_FAIL]
         && !cur_ff.prot[protmon_pkg::ST_GCB_DEACT]; // [R17]
      // stuck generator breaker while engine must stop: mains would drag it
      nxt_ff.prot[protmon_pkg::ST_MCB_OPEN_REQ] = cur_ff.ctrl[protmon_pkg::CTRL_OPEN_MCB]
         && cur_ff.prot[protmon_pkg::ST_GCB_FAIL] && pin[6]; // [R18]

      // apb slave, zero wait states
      wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
      rd = PSEL_IN && !PENABLE_IN && !PWRITE_IN;
      nxt_ff.pready = PSEL_IN && !PENABLE_IN;
      nxt_ff.pslverr = 1'b0;
      if (PSEL_IN && !PENABLE_IN) begin
         case (PADDR_IN)
            protmon_pkg::OFF_CTRL, protmon_pkg::OFF_OVS_CFG, protmon_pkg::OFF_BAT_CFG,
            protmon_pkg::OFF_STOP_CFG, protmon_pkg::OFF_CB_CFG, protmon_pkg::OFF_STATUS,
            protmon_pkg::OFF_ENG_IN: nxt_ff.pslverr = 1'b0;
            default: nxt_ff.pslverr = 1'b1;
         endcase
      end
      if (rd) begin
         case (PADDR_IN)
            protmon_pkg::OFF_CTRL: nxt_ff.prdata = cur_ff.ctrl;
            protmon_pkg::OFF_OVS_CFG: nxt_ff.prdata = cur_ff.ovs_cfg;
            protmon_pkg::OFF_BAT_CFG: nxt_ff.prdata = cur_ff.bat_cfg;
            protmon_pkg::OFF_STOP_CFG: nxt_ff.prdata = cur_ff.stop_cfg;
            protmon_pkg::OFF_CB_CFG: nxt_ff.prdata = cur_ff.cb_cfg;
            protmon_pkg::OFF_STATUS: nxt_ff.prdata = {20'h00000, cur_ff.prot};
            protmon_pkg::OFF_ENG_IN: nxt_ff.prdata = {20'h00000, pin};
            default: nxt_ff.prdata = 32'h0000_0000;
         endcase
      end
      if (wr) begin
         case (PADDR_IN)
            protmon_pkg::OFF_CTRL: nxt_ff.ctrl = PWDATA_IN;
            protmon_pkg::OFF_OVS_CFG: nxt_ff.ovs_cfg = PWDATA_IN;
            protmon_pkg::OFF_BAT_CFG: nxt_ff.bat_cfg = PWDATA_IN;
            protmon_pkg::OFF_STOP_CFG: nxt_ff.stop_cfg = PWDATA_IN;
            protmon_pkg::OFF_CB_CFG: nxt_ff.cb_cfg = PWDATA_IN;
            default: nxt_ff.ctrl = cur_ff.ctrl;
         endcase
      end
   end

   assign PRDATA_OUT = cur_ff.prdata;
   assign PREADY_OUT = cur_ff.pready;
   assign PSLVERR_OUT = cur_ff.pslverr;
   assign PROT_OUT = cur_ff.prot;
   assign KEEP_RUNNING_OUT = cur_ff.prot[protmon_pkg::ST_KEEP_RUN];
   assign MCB_OPEN_REQ_OUT = cur_ff.prot[protmon_pkg::ST_MCB_OPEN_REQ];
endmodule
`default_nettype wire

// ===== protmon_pkg.sv
// constants shared by the protection monitor and its register map
package protmon_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_OVS_CFG = 8'h04;
   localparam logic [7:0] OFF_BAT_CFG = 8'h08;
   localparam logic [7:0] OFF_STOP_CFG = 8'h0C;
   localparam logic [7:0] OFF_CB_CFG = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_ENG_IN = 8'h18;
   // control register fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_MCB_MANAGED = 2;
   localparam int CTRL_GCB_MANAGED = 3;
   localparam int CTRL_MCB_FB_USED = 4;
   localparam int CTRL_GCB_FB_USED = 5;
   localparam int CTRL_PARALLEL = 6;
   localparam int CTRL_NO_PARALLEL = 7;
   localparam int CTRL_STABLE_CLOSE = 8;
   localparam int CTRL_KEEP_RUN = 9;
   localparam int CTRL_OPEN_MCB = 10;
   localparam int CTRL_SPEED_SRC = 11;
   localparam int CTRL_AUX_BAT_CONN = 12;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // operating modes
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_MAN = 2'h1;
   localparam logic [1:0] MODE_AUTO = 2'h2;
   // status register bits
   localparam int ST_CONTACT_OVS = 0;
   localparam int ST_MEAS_OVS = 1;
   localparam int ST_AUX_BAT = 2;
   localparam int ST_NOT_STOP = 3;
   localparam int ST_NOT_START_WARN = 4;
   localparam int ST_NOT_START_ALARM = 5;
   localparam int ST_MCB_FAIL = 6;
   localparam int ST_MCB_DEACT = 7;
   localparam int ST_GCB_FAIL = 8;
   localparam int ST_GCB_DEACT = 9;
   localparam int ST_KEEP_RUN = 10;
   localparam int ST_MCB_OPEN_REQ = 11;
   // timing: one delay tick is 1 ms, seconds for stop cycle
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 1;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int MS_PER_S = 1000;
   localparam logic [15:0] PAR_FB_DELAY_MS = 16'h07D0; // 2 s substitute in parallel use
   localparam logic [1:0] AUTO_ATTEMPTS = 2'h3;
   localparam logic [1:0] ONE_ATTEMPT = 2'h1;
endpackage

// ===== protmon_props.sv
// port checker for the protection monitor
`timescale 1ns/10ps
`default_nettype none
module protmon_props #(
   parameter int TICK_DIV = 10
) (
   input wire logic CLOCK_IN, // clock
   input wire logic RST_N_IN, // reset
   input wire logic PSEL_IN, // select
   input wire logic PENABLE_IN, // enable
   input wire logic PREADY_OUT, // ready
   input wire logic PSLVERR_OUT, // error
   input wire logic OVERSPEED_CONTACT_IN, // contact
   input wire logic ENGINE_STARTING_IN, // start phase
   input wire logic DPF_REGEN_IN, // regeneration
   input wire logic [11:0] PROT_OUT // flags
);
   default clocking dc @(posedge CLOCK_IN);
   endclocking
   default disable iff (!RST_N_IN);
   // keep-running and mains request flags trail the fail flag by one stage, hence the past terms
   apb_ready_a: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT)
      else $error("no ready in access phase");
   ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
      else $error("ready held too long");
   err_ready_a: assert property (PSLVERR_OUT |-> PREADY_OUT)
      else $error("error without ready");
   start_quiet_a: assert property (ENGINE_STARTING_IN [*5] |-> PROT_OUT[1:0] == 2'h0)
      else $error("overspeed while starting");
   regen_quiet_a: assert property (DPF_REGEN_IN [*5] |-> PROT_OUT[1:0] == 2'h0)
      else $error("overspeed while regenerating");
   contact_hold_a: assert property ($rose(PROT_OUT[0]) |->
      $past(OVERSPEED_CONTACT_IN, 4) && $past(OVERSPEED_CONTACT_IN, 9))
      else $error("contact alarm without held input");
   start_grade_a: assert property (!(PROT_OUT[4] && PROT_OUT[5]))
      else $error("warning and alarm together");
   deact_grade_a: assert property (PROT_OUT[9] |-> PROT_OUT[8] || $past(PROT_OUT[8]))
      else $error("deactivation without fail");
   keep_run_a: assert property (PROT_OUT[10] |-> PROT_OUT[8] || $past(PROT_OUT[8]))
      else $error("keep running without fail");
   mains_req_a: assert property (PROT_OUT[11] |-> PROT_OUT[8] || $past(PROT_OUT[8]))
      else $error("mains open request without fail");
endmodule
bind genset_protection_monitor protmon_props #(.TICK_DIV(TICK_DIV)) i_props (
   .CLOCK_IN(CLOCK_IN),
   .RST_N_IN(RST_N_IN),
   .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN),
   .PREADY_OUT(PREADY_OUT),
   .PSLVERR_OUT(PSLVERR_OUT),
   .OVERSPEED_CONTACT_IN(OVERSPEED_CONTACT_IN),
   .ENGINE_STARTING_IN(ENGINE_STARTING_IN),
   .DPF_REGEN_IN(DPF_REGEN_IN),
   .PROT_OUT(PROT_OUT)
);
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the protection monitor
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, keep, mreq, mcb_fb, gcb_fb;
   logic contact = 1'b0, running = 1'b0, starting = 1'b0, regen = 1'b0, crank = 1'b0;
   logic start_c = 1'b0, stop_c = 1'b0, mcb_open = 1'b0, mcb_close = 1'b0;
   logic gcb_open = 1'b0, gcb_close = 1'b0, stuck = 1'b0, force_m = 1'b0;
   logic [15:0] speed = 16'h0000, aux = 16'h0000;
   logic [11:0] prot;
   int n_errors = 0, checks_done = 0, cyc = 0;
   initial forever #5 clk = ~clk;
   // short tick divider keeps millisecond delays cheap to simulate
   genset_protection_monitor #(.TICK_DIV(10)) i_genset_protection_monitor (
      .CLOCK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
      .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .OVERSPEED_CONTACT_IN(contact), .ENGINE_RUNNING_IN(running),
      .ENGINE_STARTING_IN(starting), .DPF_REGEN_IN(regen), .START_CMD_IN(start_c),
      .STOP_CMD_IN(stop_c), .CRANK_FAIL_IN(crank), .MCB_OPEN_CMD_IN(mcb_open),
      .MCB_CLOSE_CMD_IN(mcb_close), .MCB_CLOSED_FB_IN(mcb_fb), .GCB_OPEN_CMD_IN(gcb_open),
      .GCB_CLOSE_CMD_IN(gcb_close), .GCB_CLOSED_FB_IN(gcb_fb), .SPEED_RPM_IN(speed),
      .AUX_BAT_PCT_IN(aux), .PROT_OUT(prot), .KEEP_RUNNING_OUT(keep), .MCB_OPEN_REQ_OUT(mreq));
   breaker_model i_mcb (.clk_in(clk), .rst_n_in(rst_n), .open_in(mcb_open),
      .close_in(mcb_close), .stuck_in(stuck), .force_in(force_m), .closed_out(mcb_fb));
   breaker_model i_gcb (.clk_in(clk), .rst_n_in(rst_n), .open_in(gcb_open),
      .close_in(gcb_close), .stuck_in(stuck), .force_in(1'b0), .closed_out(gcb_fb));
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   // compare {mains request, keep running, flags} under a mask
   task automatic pc(input logic [13:0] m, input logic [13:0] e);
      chk("flags", {18'h0, e}, {18'h0, {mreq, keep, prot} & m});
   endtask
   // one transfer; a read compares against d, the idle edge gives the spacing
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
      psel <= 1'b1;
      pwr <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk iff pready);
      if (!wr) chk("PRDATA_OUT", d, prdata);
      chk("PSLVERR_OUT", {31'h0, err}, {31'h0, pslverr});
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic ovs(input int n, input logic e);
      contact <= 1'b1;
      tick(n);
      pc(14'h0001, {13'h0, e});
      contact <= 1'b0;
      tick(10);
      pc(14'h0001, 14'h0000);
   endtask
   // clear the attempt count with a healthy opening, then n jammed attempts
   task automatic try(input logic [31:0] c, input int n, input logic [13:0] m, input logic [13:0] e);
      acc(1, 8'h00, c, 0);
      stuck <= 1'b0;
      gcb_open <= 1'b1;
      tick(30);
      gcb_open <= 1'b0;
      stuck <= 1'b1;
      tick(10);
      for (int i = 0; i < n; i++) begin
         gcb_open <= 1'b1;
         tick(40);
         if (i == n - 1) pc(m, e);
         else pc(14'h0100, 14'h0000);
         gcb_open <= 1'b0;
         tick(10);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // hang guard, well above the roughly 33400 cycles of the sequence
   always @(posedge clk) begin
      cyc++;
      if (cyc == 70000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      tick(20);
      rst_n <= 1'b1;
      tick(3);
      acc(0, protmon_pkg::OFF_CTRL, protmon_pkg::CTRL_RESET, 0);
      acc(1, 8'h00, 32'h0002_1FFE, 0);
      acc(0, 8'h00, 32'h0002_1FFE, 0);
      acc(1, 8'h00, 32'h0000_0000, 0);
      acc(1, 8'h14, 32'h0000_0FFF, 0);
      acc(0, 8'h14, 32'h0000_0000, 0);
      acc(0, 8'h1C, 32'h0000_0000, 1);
      $display("register test done");
      running <= 1'b1;
      start_c <= 1'b1;
      acc(1, 8'h04, 32'h0000_0003, 0);
      acc(1, 8'h00, 32'h0000_0001, 0);
      ovs(20, 0);
      ovs(20, 0);
      ovs(60, 1);
      starting <= 1'b1;
      ovs(60, 0);
      starting <= 1'b0;
      regen <= 1'b1;
      ovs(60, 0);
      regen <= 1'b0;
      acc(1, 8'h04, 32'h0000_0000, 0);
      ovs(60, 0);
      acc(1, 8'h04, 32'h0000_0003, 0);
      acc(1, 8'h00, 32'h0000_0000, 0);
      ovs(60, 0);
      acc(1, 8'h0C, 32'h05DC_0000, 0);
      acc(1, 8'h04, 32'h0002_0000, 0);
      acc(1, 8'h00, 32'h0000_0801, 0);
      speed <= 16'h05DD;
      tick(50);
      pc(14'h0002, 14'h0002);
      speed <= 16'h05DC;
      tick(50);
      pc(14'h0002, 14'h0000);
      speed <= 16'h05DD;
      acc(1, 8'h00, 32'h0000_0001, 0);
      tick(50);
      pc(14'h0002, 14'h0000);
      speed <= 16'h0000;
      acc(1, 8'h08, 32'h0002_0078, 0);
      acc(1, 8'h00, 32'h0000_1000, 0);
      aux <= 16'h0079;
      tick(50);
      pc(14'h0004, 14'h0004);
      aux <= 16'h0078;
      tick(50);
      pc(14'h0004, 14'h0000);
      aux <= 16'h0079;
      acc(1, 8'h00, 32'h0000_0000, 0);
      tick(50);
      pc(14'h0004, 14'h0000);
      $display("overspeed and battery tests done");
      acc(1, 8'h0C, 32'h05DC_0001, 0);
      start_c <= 1'b0;
      stop_c <= 1'b1;
      tick(9000);
      pc(14'h0008, 14'h0000);
      tick(1500);
      pc(14'h0008, 14'h0008);
      stop_c <= 1'b0;
      running <= 1'b0;
      tick(20);
      running <= 1'b1;
      tick(20);
      pc(14'h0008, 14'h0008);
      running <= 1'b0;
      for (int md = 1; md < 3; md++) begin
         acc(1, 8'h00, {8'h00, 8'h02, 14'h0, md[1:0]}, 0);
         repeat (2) begin
            crank <= 1'b1;
            tick(4);
            crank <= 1'b0;
            tick(4);
         end
         tick(10);
         pc(14'h0030, md == 1 ? 14'h0010 : 14'h0020);
      end
      $display("engine tests done");
      acc(1, 8'h10, 32'h0002_0002, 0);
      gcb_close <= 1'b1;
      try(32'h0000_0029, 1, 14'h0300, 14'h0100);
      try(32'h0000_002A, 3, 14'h0100, 14'h0100);
      try(32'h0000_012A, 1, 14'h0100, 14'h0100);
      try(32'h0000_00A9, 1, 14'h0300, 14'h0300);
      try(32'h0000_0021, 1, 14'h0100, 14'h0000);
      try(32'h0000_0009, 1, 14'h0100, 14'h0000);
      try(32'h0000_0229, 1, 14'h1500, 14'h1500);
      stop_c <= 1'b1;
      try(32'h0000_0429, 1, 14'h2900, 14'h2900);
      stop_c <= 1'b0;
      acc(1, 8'h10, 32'h0000_0000, 0);
      try(32'h0000_0029, 1, 14'h0100, 14'h0000);
      acc(1, 8'h00, 32'h0000_0069, 0);
      gcb_open <= 1'b1;
      tick(19000);
      pc(14'h0100, 14'h0000);
      tick(2000);
      pc(14'h0100, 14'h0100);
      gcb_open <= 1'b0;
      acc(1, 8'h10, 32'h0002_0002, 0);
      acc(1, 8'h00, 32'h0000_0015, 0);
      force_m <= 1'b1;
      tick(30);
      pc(14'h00C0, 14'h00C0);
      force_m <= 1'b0;
      mcb_close <= 1'b1;
      mcb_open <= 1'b1;
      tick(40);
      pc(14'h00C0, 14'h0040);
      mcb_open <= 1'b0;
      $display("breaker tests done");
      summarize();
   end
endmodule
`default_nettype wire
